/* File: acrb_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Outside world at the pins: ready line and I/O pin drivers
module acrb_pin_model (
  // Levels wanted by the bench
  input wire logic ready_n_drive,
  input wire logic [7:0] ext_drive,
  // Device pin drive
  input wire logic [7:0] io_out,
  input wire logic [7:0] io_oe,
  // Resolved pin levels
  output logic ready_n_pin,
  output logic [7:0] io_level
);
  // Ready line is a push-pull output of the converter core
  assign ready_n_pin = ready_n_drive;
  // A pin follows the device where it drives, the outside otherwise
  assign io_level = (io_out & io_oe) | (ext_drive & ~io_oe);
endmodule
`default_nettype wire

/* File: acrb_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Three-stage pin synchroniser; a change counts once stages agree
module acrb_pin_sync #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Pins and filtered level
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (srst) begin
      stage1_reg <= RESET_VAL;
      stage2_reg <= RESET_VAL;
      stage3_reg <= RESET_VAL;
    end else begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // Accept a bit where the last two stages agree, hold it otherwise
  always_ff @(posedge mclk) begin
    if (srst) begin
      level_out <= RESET_VAL;
    end else begin
      level_out <= (stage3_reg & ~(stage2_reg ^ stage3_reg)) |
                   (level_out & (stage2_reg ^ stage3_reg));
    end
  end

endmodule
`default_nettype wire

/* File: acrb_pkg.sv */
// ==========================================================
// Register map, reset values and field positions
package acrb_pkg;

  // ==========================================================
  // Register addresses
  localparam logic [3:0] ACRB_ADDR_ACR = 4'h2;
  localparam logic [3:0] ACRB_ADDR_SRC1 = 4'h3;
  localparam logic [3:0] ACRB_ADDR_SRC2 = 4'h4;
  localparam logic [3:0] ACRB_ADDR_TRIM = 4'h5;
  localparam logic [3:0] ACRB_ADDR_DIO = 4'h6;
  localparam logic [3:0] ACRB_ADDR_DIR = 4'h7;
  localparam logic [3:0] ACRB_ADDR_RLO = 4'h8;
  localparam logic [3:0] ACRB_ADDR_MODE = 4'h9;
  localparam logic [3:0] ACRB_ADDR_OCL = 4'hA;
  localparam logic [3:0] ACRB_ADDR_OCM = 4'hB;
  localparam logic [3:0] ACRB_ADDR_OCH = 4'hC;
  localparam logic [3:0] ACRB_ADDR_GCL = 4'hD;
  localparam logic [3:0] ACRB_ADDR_GCM = 4'hE;
  localparam logic [3:0] ACRB_ADDR_GCH = 4'hF;

  // ==========================================================
  // Reset values
  localparam logic [7:0] ACRB_RST_ACR = 8'h00;
  localparam logic [7:0] ACRB_RST_SRC = 8'h00;
  localparam logic [7:0] ACRB_RST_TRIM = 8'h00;
  localparam logic [7:0] ACRB_RST_DIO = 8'h00;
  localparam logic [7:0] ACRB_RST_DIR = 8'hFF;
  localparam logic [7:0] ACRB_RST_RLO = 8'h80;
  localparam logic [7:0] ACRB_RST_MODE = 8'h07;
  localparam logic [7:0] ACRB_RST_OCL = 8'h00;
  localparam logic [7:0] ACRB_RST_OCM = 8'h00;
  localparam logic [7:0] ACRB_RST_OCH = 8'h00;
  localparam logic [7:0] ACRB_RST_GCL = 8'h24;
  localparam logic [7:0] ACRB_RST_GCM = 8'h00;
  localparam logic [7:0] ACRB_RST_GCH = 8'h67;
  localparam logic [7:0] ACRB_RST_READ = 8'h00;

  // ==========================================================
  // Field positions
  localparam int ACRB_BIT_BURNOUT = 7;
  localparam int ACRB_BIT_SIGN = 7;
  localparam int ACRB_BIT_READY = 7;
  localparam int ACRB_BIT_FORMAT = 6;

  // ==========================================================
  // Decimation ratio limits
  localparam logic [10:0] ACRB_RATIO_MIN = 11'h014;
  localparam logic [10:0] ACRB_RATIO_MAX = 11'h7FF;

  // ==========================================================
  // Settling modes
  typedef enum logic [1:0] {
    ACRB_SETTLE_AUTO = 2'b00,
    ACRB_SETTLE_FAST = 2'b01,
    ACRB_SETTLE_SINC2 = 2'b10,
    ACRB_SETTLE_SINC3 = 2'b11
  } acrb_settle_t;

  // Gain code to power-of-two gain factor
  function automatic logic [7:0] acrb_gain_factor(input logic [2:0] code);
    acrb_gain_factor = 8'h01 << code;
  endfunction

endpackage

/* File: acrb_register_bank.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Analog control bit 7 switches burnout current sources on when set.
// - Analog control bits 6-5 select source two range; 00 is off.
// - Analog control bits 4-3 select source one range; 00 is off.
// - Analog control bits 2-0 give gain as power of two, 1 to 128.
// - Each current source code scales its output linearly; both reset zero.
// - Direction bit 0 makes its pin an output, 1 an input.
// - Direction byte resets to all ones, every pin an input.
// - Decimation ratio is 11 bits; host keeps it within 20 to 2047.
// - Low ratio byte resets 80h; high ratio bits in mode bits 2-0.
// - Mode bit 7 mirrors ready pin level; writes to it ignored.
// - Mode bit 6 selects unipolar when set, two's complement when clear.
// - Mode bits 5-4 select auto, fast, sinc2 or sinc3 settling.
// - Analog control byte sits at address 02h and resets to zero.
module acrb_register_bank
  import acrb_pkg::*;
#(
  parameter logic [7:0] TRIM_RESET = ACRB_RST_TRIM,
  parameter logic [7:0] OCL_RESET = ACRB_RST_OCL,
  parameter logic [7:0] GCM_RESET = ACRB_RST_GCM
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Register access port from the command decoder
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Pins sampled from outside
  input wire logic conversion_ready_n_pin,
  input wire logic [7:0] general_io_in,
  // Digital I/O pin drive
  output logic [7:0] general_io_out,
  output logic [7:0] general_io_oe,
  // Analog controls
  output logic burnout_source_enable,
  output logic [1:0] source_two_range,
  output logic [1:0] source_one_range,
  output logic [2:0] gain_code,
  output logic [7:0] gain_factor,
  output logic [7:0] current_source_one_code,
  output logic [7:0] current_source_two_code,
  output logic offset_negative,
  output logic [6:0] offset_magnitude,
  // Filter and format controls
  output logic [10:0] decimation_ratio,
  output logic ratio_in_range,
  output logic unipolar_format,
  output acrb_settle_t settling_mode,
  // Calibration coefficients
  output logic [23:0] offset_cal,
  output logic [23:0] gain_cal
);

  // ==========================================================
  // Storage
  logic [7:0] acr_reg;
  logic [7:0] src1_reg;
  logic [7:0] src2_reg;
  logic [7:0] trim_reg;
  logic [7:0] dio_reg;
  logic [7:0] dir_reg;
  logic [7:0] rlo_reg;
  logic [6:0] mode_reg;
  logic [23:0] ocal_reg;
  logic [23:0] gcal_reg;
  logic [7:0] rdata_next;
  logic ready_level;
  logic [7:0] io_level;

  // ==========================================================
  // Pin synchronisers
  acrb_pin_sync #(
    .WIDTH(9),
    .RESET_VAL(9'h100)
  ) u_pin_sync (
    .mclk(mclk),
    .srst(srst),
    .pin_in({conversion_ready_n_pin, general_io_in}),
    .level_out({ready_level, io_level})
  );

  // Write decode helper
  function automatic logic wr_hit(input logic [3:0] a);
    wr_hit = reg_wr && (reg_addr == a);
  endfunction

  // ==========================================================
  // Analog control and current source codes
  always_ff @(posedge mclk) begin
    if (srst) begin
      acr_reg <= ACRB_RST_ACR;
      src1_reg <= ACRB_RST_SRC;
      src2_reg <= ACRB_RST_SRC;
      trim_reg <= TRIM_RESET;
    end else begin
      if (wr_hit(ACRB_ADDR_ACR)) begin
        acr_reg <= reg_wdata;
      end
      if (wr_hit(ACRB_ADDR_SRC1)) begin
        src1_reg <= reg_wdata;
      end
      if (wr_hit(ACRB_ADDR_SRC2)) begin
        src2_reg <= reg_wdata;
      end
      if (wr_hit(ACRB_ADDR_TRIM)) begin
        trim_reg <= reg_wdata;
      end
    end
  end

  // Digital I/O latch and direction
  always_ff @(posedge mclk) begin
    if (srst) begin
      dio_reg <= ACRB_RST_DIO;
      dir_reg <= ACRB_RST_DIR;
    end else begin
      if (wr_hit(ACRB_ADDR_DIO)) begin
        dio_reg <= reg_wdata;
      end
      if (wr_hit(ACRB_ADDR_DIR)) begin
        dir_reg <= reg_wdata;
      end
    end
  end

  // Decimation ratio and mode; ready bit is never stored
  always_ff @(posedge mclk) begin
    if (srst) begin
      rlo_reg <= ACRB_RST_RLO;
      mode_reg <= ACRB_RST_MODE[6:0];
    end else begin
      if (wr_hit(ACRB_ADDR_RLO)) begin
        rlo_reg <= reg_wdata;
      end
      if (wr_hit(ACRB_ADDR_MODE)) begin
        mode_reg <= reg_wdata[6:0];
      end
    end
  end

  // Calibration coefficients, one byte lane per address
  always_ff @(posedge mclk) begin
    if (srst) begin
      ocal_reg <= {ACRB_RST_OCH, ACRB_RST_OCM, OCL_RESET};
      gcal_reg <= {ACRB_RST_GCH, GCM_RESET, ACRB_RST_GCL};
    end else begin
      if (wr_hit(ACRB_ADDR_OCL)) begin
        ocal_reg[7:0] <= reg_wdata;
      end
      if (wr_hit(ACRB_ADDR_OCM)) begin
        ocal_reg[15:8] <= reg_wdata;
      end
      if (wr_hit(ACRB_ADDR_OCH)) begin
        ocal_reg[23:16] <= reg_wdata;
      end
      if (wr_hit(ACRB_ADDR_GCL)) begin
        gcal_reg[7:0] <= reg_wdata;
      end
      if (wr_hit(ACRB_ADDR_GCM)) begin
        gcal_reg[15:8] <= reg_wdata;
      end
      if (wr_hit(ACRB_ADDR_GCH)) begin
        gcal_reg[23:16] <= reg_wdata;
      end
    end
  end

  // ==========================================================
  // Field outputs straight from storage
  assign burnout_source_enable = acr_reg[ACRB_BIT_BURNOUT];
  assign source_two_range = acr_reg[6:5];
  assign source_one_range = acr_reg[4:3];
  assign gain_code = acr_reg[2:0];
  assign current_source_one_code = src1_reg;
  assign current_source_two_code = src2_reg;
  assign offset_negative = trim_reg[ACRB_BIT_SIGN];
  assign offset_magnitude = trim_reg[6:0];
  assign decimation_ratio = {mode_reg[2:0], rlo_reg};
  assign unipolar_format = mode_reg[ACRB_BIT_FORMAT];
  assign settling_mode = acrb_settle_t'(mode_reg[5:4]);
  assign offset_cal = ocal_reg;
  assign gain_cal = gcal_reg;
  assign general_io_out = dio_reg;

  // Registered derived outputs: gain, pin drive, ratio check
  always_ff @(posedge mclk) begin
    if (srst) begin
      gain_factor <= acrb_gain_factor(ACRB_RST_ACR[2:0]);
      general_io_oe <= ~ACRB_RST_DIR;
      ratio_in_range <= 1'b1;
    end else begin
      gain_factor <= acrb_gain_factor(acr_reg[2:0]);
      general_io_oe <= ~dir_reg;
      ratio_in_range <= (decimation_ratio >= ACRB_RATIO_MIN) &&
                        (decimation_ratio <= ACRB_RATIO_MAX);
    end
  end

  // ==========================================================
  // Read data selection
  always_comb begin
    case (reg_addr)
      ACRB_ADDR_ACR: rdata_next = acr_reg;
      ACRB_ADDR_SRC1: rdata_next = src1_reg;
      ACRB_ADDR_SRC2: rdata_next = src2_reg;
      ACRB_ADDR_TRIM: rdata_next = trim_reg;
      ACRB_ADDR_DIO: rdata_next = (io_level & dir_reg) | (dio_reg & ~dir_reg);
      ACRB_ADDR_DIR: rdata_next = dir_reg;
      ACRB_ADDR_RLO: rdata_next = rlo_reg;
      ACRB_ADDR_MODE: rdata_next = {ready_level, mode_reg};
      ACRB_ADDR_OCL: rdata_next = ocal_reg[7:0];
      ACRB_ADDR_OCM: rdata_next = ocal_reg[15:8];
      ACRB_ADDR_OCH: rdata_next = ocal_reg[23:16];
      ACRB_ADDR_GCL: rdata_next = gcal_reg[7:0];
      ACRB_ADDR_GCM: rdata_next = gcal_reg[15:8];
      ACRB_ADDR_GCH: rdata_next = gcal_reg[23:16];
      default: rdata_next = ACRB_RST_READ;
    endcase
  end

  // Read answer one cycle after the request
  always_ff @(posedge mclk) begin
    if (srst) begin
      reg_rdata <= ACRB_RST_READ;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_next;
      end
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  property p_burnout;
    wr_hit(ACRB_ADDR_ACR) |=>
      burnout_source_enable == $past(reg_wdata[7]);
  endproperty
  a_burnout: assert property (p_burnout)
    else $error("burnout enable did not follow write");

  property p_range_two;
    wr_hit(ACRB_ADDR_ACR) |=> source_two_range == $past(reg_wdata[6:5]);
  endproperty
  a_range_two: assert property (p_range_two)
    else $error("source two range did not follow write");

  property p_range_one;
    wr_hit(ACRB_ADDR_ACR) |=> source_one_range == $past(reg_wdata[4:3]);
  endproperty
  a_range_one: assert property (p_range_one)
    else $error("source one range did not follow write");

  property p_gain;
    wr_hit(ACRB_ADDR_ACR) ##1 !wr_hit(ACRB_ADDR_ACR) |=>
      gain_factor == acrb_gain_factor($past(reg_wdata[2:0], 2));
  endproperty
  a_gain: assert property (p_gain)
    else $error("gain factor wrong after write");

  property p_reset_vals;
    $fell(srst) |-> dir_reg == ACRB_RST_DIR && src1_reg == ACRB_RST_SRC &&
      src2_reg == ACRB_RST_SRC && acr_reg == ACRB_RST_ACR &&
      rlo_reg == ACRB_RST_RLO;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("register not at reset value after reset");

  property p_dir_oe;
    wr_hit(ACRB_ADDR_DIR) ##1 !wr_hit(ACRB_ADDR_DIR) |=>
      general_io_oe == ~$past(reg_wdata, 2);
  endproperty
  a_dir_oe: assert property (p_dir_oe)
    else $error("pin drive enable not inverse of direction");

  property p_ratio_flag;
    !$rose(srst) |=> ratio_in_range ==
      ($past(decimation_ratio) >= ACRB_RATIO_MIN);
  endproperty
  a_ratio_flag: assert property (p_ratio_flag)
    else $error("ratio range flag wrong");

  property p_ratio_low;
    wr_hit(ACRB_ADDR_RLO) |=> decimation_ratio[7:0] == $past(reg_wdata);
  endproperty
  a_ratio_low: assert property (p_ratio_low)
    else $error("low ratio byte not stored");

  property p_ready_mirror;
    reg_rd && reg_addr == ACRB_ADDR_MODE |=>
      reg_rvalid && reg_rdata[7] == $past(ready_level);
  endproperty
  a_ready_mirror: assert property (p_ready_mirror)
    else $error("ready bit not mirrored on read");

  property p_mode_fields;
    wr_hit(ACRB_ADDR_MODE) |=> unipolar_format == $past(reg_wdata[6]) &&
      settling_mode == $past(reg_wdata[5:4]);
  endproperty
  a_mode_fields: assert property (p_mode_fields)
    else $error("format or settling not stored");

  property p_trim;
    wr_hit(ACRB_ADDR_TRIM) |=> offset_negative == $past(reg_wdata[7]) &&
      offset_magnitude == $past(reg_wdata[6:0]);
  endproperty
  a_trim: assert property (p_trim)
    else $error("trim sign or magnitude wrong");

  property p_ocal_high;
    wr_hit(ACRB_ADDR_OCH) |=> offset_cal[23:16] == $past(reg_wdata);
  endproperty
  a_ocal_high: assert property (p_ocal_high)
    else $error("offset high byte not stored");

  property p_hold;
    !reg_wr |=> $stable(acr_reg) && $stable(dir_reg) && $stable(ocal_reg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("register changed without a write");

  c_write_acr: cover property (wr_hit(ACRB_ADDR_ACR) ##1 reg_rd);
  c_read_mode: cover property (reg_rd && reg_addr == ACRB_ADDR_MODE);
  c_pins_out: cover property (wr_hit(ACRB_ADDR_DIR) && reg_wdata == 8'h00);
  c_ratio_bad: cover property (!ratio_in_range);

endmodule
`default_nettype wire

/* File: adc_config_register_bank_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_config_register_bank_tb;
  import acrb_pkg::*;
  // ==========================================================
  // Signals
  logic mclk, srst, reg_wr, reg_rd, reg_rvalid, ready_n, rdy_pin;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, general_io_out, general_io_oe;
  logic [7:0] ext_drive, io_level, gain_factor, src1, src2, analog_control;
  logic burnout_source_enable, offset_negative, ratio_in_range;
  logic unipolar_format;
  logic [1:0] source_two_range, source_one_range;
  logic [2:0] gain_code;
  logic [6:0] offset_magnitude;
  logic [10:0] decimation_ratio;
  acrb_settle_t settling_mode;
  logic [23:0] offset_cal, gain_cal;
  logic [7:0] rst_tab [16];
  int err_total, checks_done;

  // ==========================================================
  // Device and its pin surroundings
  acrb_register_bank dut (
    .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .conversion_ready_n_pin(rdy_pin),
    .general_io_in(io_level), .general_io_out(general_io_out),
    .general_io_oe(general_io_oe),
    .burnout_source_enable(burnout_source_enable),
    .source_two_range(source_two_range),
    .source_one_range(source_one_range), .gain_code(gain_code),
    .gain_factor(gain_factor), .current_source_one_code(src1),
    .current_source_two_code(src2), .offset_negative(offset_negative),
    .offset_magnitude(offset_magnitude),
    .decimation_ratio(decimation_ratio), .ratio_in_range(ratio_in_range),
    .unipolar_format(unipolar_format), .settling_mode(settling_mode),
    .offset_cal(offset_cal), .gain_cal(gain_cal)
  );
  acrb_pin_model pins (
    .ready_n_drive(ready_n), .ext_drive(ext_drive),
    .io_out(general_io_out), .io_oe(general_io_oe),
    .ready_n_pin(rdy_pin), .io_level(io_level)
  );

  // ==========================================================
  // Clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ==========================================================
  // Compare, access and closing tasks
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    @(negedge mclk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    chk(24'(reg_rvalid), 24'h000001);
    chk(24'(reg_rdata), 24'(exp));
    @(negedge mclk);
    chk(24'(reg_rvalid), 24'h000000);
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================
  // Watchdog well beyond the expected run of about 145 cycles
  initial begin
    repeat (3000) @(posedge mclk);
    err_total++;
    give_verdict();
  end

  // ==========================================================
  // Test sequence
  initial begin
    rst_tab = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3C, 8'hFF,
                8'h80, 8'h87, 8'h00, 8'h00, 8'h00, 8'h24, 8'h00, 8'h67};
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    ready_n = 1'b1;
    ext_drive = 8'h3C;
    err_total = 0;
    checks_done = 0;
    repeat (6) @(negedge mclk);
    srst = 1'b0;
    @(negedge mclk);
    // Reset values, with pin levels at DIO and mode bit 7, unmapped addresses read zero
    for (int i = 0; i < 16; i++)
      rd(4'(i), rst_tab[i]);
    // Analog control fields, all range codes and gain steps
    for (int i = 0; i < 8; i++) begin
      analog_control = {i[0], i[1:0], ~i[1:0], i[2:0]};
      wr(ACRB_ADDR_ACR, analog_control);
      chk(24'(burnout_source_enable), 24'(i[0]));
      chk(24'(source_two_range), 24'(i[1:0]));
      chk(24'(source_one_range), 24'(i[1:0] ^ 2'b11));
      chk(24'(gain_code), 24'(i[2:0]));
      chk(24'(gain_factor), 24'(8'h01 << i[2:0]));
      rd(ACRB_ADDR_ACR, analog_control);
    end
    // Current source codes and sign-magnitude trim
    wr(ACRB_ADDR_SRC1, 8'hFF);
    wr(ACRB_ADDR_SRC2, 8'h5A);
    chk(24'(src1), 24'h0000FF);
    chk(24'(src2), 24'h00005A);
    wr(ACRB_ADDR_TRIM, 8'h85);
    chk(24'({offset_negative, offset_magnitude}), 24'h000085);
    wr(ACRB_ADDR_TRIM, 8'h7F);
    chk(24'(offset_negative), 24'h000000);
    chk(24'(offset_magnitude), 24'h00007F);
    // Calibration coefficients from three bytes each
    for (int i = 0; i < 6; i++)
      wr(4'(10 + i), 8'(8'h11 * (i + 1)));
    chk(offset_cal, 24'h332211);
    chk(gain_cal, 24'h665544);
    rd(ACRB_ADDR_OCM, 8'h22);
    // Ready mirror ignores writes; ratio 19 rejected, 20 accepted
    ready_n = 1'b0;
    repeat (6) @(negedge mclk);
    wr(ACRB_ADDR_RLO, 8'h13);
    wr(ACRB_ADDR_MODE, 8'hF0);
    chk(24'(decimation_ratio), 24'h000013);
    chk(24'(ratio_in_range), 24'h000000);
    chk(24'(unipolar_format), 24'h000001);
    rd(ACRB_ADDR_MODE, 8'h70);
    wr(ACRB_ADDR_RLO, 8'h14);
    chk(24'(ratio_in_range), 24'h000001);
    // Every settling mode with the top ratio bits set
    for (int s = 0; s < 4; s++) begin
      wr(ACRB_ADDR_MODE, {2'b00, 2'(s), 4'h7});
      chk(24'(settling_mode), 24'(s));
      chk(24'(unipolar_format), 24'h000000);
    end
    chk(24'(decimation_ratio), 24'h000714);
    wr(ACRB_ADDR_RLO, 8'hFF);
    chk(24'(ratio_in_range), 24'h000001);
    ready_n = 1'b1;
    repeat (6) @(negedge mclk);
    rd(ACRB_ADDR_MODE, 8'hB7);
    // Direction: upper pins driven, lower pins read from outside
    wr(ACRB_ADDR_DIR, 8'h0F);
    wr(ACRB_ADDR_DIO, 8'hA5);
    chk(24'(general_io_oe), 24'h0000F0);
    chk(24'(general_io_out), 24'h0000A5);
    repeat (6) @(negedge mclk);
    rd(ACRB_ADDR_DIO, 8'hAC);
    // Second reset mid-run brings reset values back
    srst = 1'b1;
    @(negedge mclk);
    srst = 1'b0;
    @(negedge mclk);
    rd(ACRB_ADDR_ACR, 8'h00);
    rd(ACRB_ADDR_DIR, 8'hFF);
    chk(gain_cal, 24'h670024);
    chk(offset_cal, 24'h000000);
    give_verdict();
  end
endmodule
`default_nettype wire
